// File: dsvf_pkg.sv
// dual stream video fader: constants and carrier types
// assumes a single 20 MHz system clock; all users import the whole package
package dsvf_pkg;
  // pixel port and timing codes
  localparam int unsigned WORD_W = 8;
  localparam logic [7:0] CODE_FF = 8'hFF;
  localparam logic [7:0] CODE_00 = 8'h00;
  localparam int unsigned CODE_H_BIT = 4;
  // levels used at and after reset
  localparam logic [7:0] BLACK_Y = 8'h10;
  localparam logic [7:0] CHROMA_MID = 8'h80;
  localparam logic [7:0] RGB_MIN = 8'h00;
  // colour bar generator
  localparam int unsigned ACTIVE_PIXELS_DEF = 720;
  localparam int unsigned BAR_STEPS = 8;
  localparam logic [7:0][23:0] BAR_TABLE = {24'h108080, 24'h23D472, 24'h4164D4,
    24'h54B8C6, 24'h70483A, 24'h839C2C, 24'hA22C8E, 24'hB48080};
  // dematrix coefficients, scaled by 256
  localparam logic signed [19:0] DM_RV = 20'sh00167;
  localparam logic signed [19:0] DM_GU = 20'sh00058;
  localparam logic signed [19:0] DM_GV = 20'sh000B7;
  localparam logic signed [19:0] DM_BU = 20'sh001C6;
  localparam int unsigned DM_SHIFT = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FADE = 8'h04;
  localparam logic [7:0] OFS_KEY1_LO = 8'h08;
  localparam logic [7:0] OFS_KEY1_HI = 8'h0C;
  localparam logic [7:0] OFS_KEY2_LO = 8'h10;
  localparam logic [7:0] OFS_KEY2_HI = 8'h14;
  localparam logic [7:0] OFS_LUT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  // control bit positions
  localparam int unsigned CB_EDGE_FIRST = 0;
  localparam int unsigned CB_EDGE_SECOND = 1;
  localparam int unsigned CB_CODE_DET = 2;
  localparam int unsigned CB_SLAVE = 3;
  localparam int unsigned CB_TFADE_MPEG = 4;
  localparam int unsigned CB_TFADE_VIDEO = 5;
  localparam int unsigned CB_IGNORE_KEYS = 6;
  localparam int unsigned CB_RGB_SEL = 7;
  localparam int unsigned CB_COMP_SEL = 8;
  localparam int unsigned CB_TEST_BARS = 9;
  localparam int unsigned CB_DEMATRIX_BYP = 10;
  localparam int unsigned CB_EARLY_SYNC = 11;
  localparam int unsigned CB_PAL = 12;
  localparam int unsigned EARLY_LSB = 16;
  localparam int unsigned EARLY_W = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_1000;
  // fade factor field positions
  localparam int unsigned FADE_W = 6;
  localparam int unsigned FADE_FACTOR_KEY_ONE_LSB = 0;
  localparam int unsigned FADE_FACTOR_TABLE_LSB = 8;
  localparam int unsigned FADE_FACTOR_UNKEYED_LSB = 16;
  // carriers
  typedef struct packed {logic [7:0] y; logic [7:0] u; logic [7:0] v;} dsvf_yuv_t;
  typedef struct packed {logic [7:0] r; logic [7:0] g; logic [7:0] b;} dsvf_rgb_t;
  typedef struct packed {logic valid; dsvf_yuv_t pix;} dsvf_pix_t;
endpackage

// File: dsvf_stream_deser.sv
// dual stream video fader: word demultiplexer and code finder
// assumes word strobes come from logic on the same clock
module dsvf_stream_deser
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // incoming words
  input wire logic wordStrobe,
  input wire logic [7:0] wordIn,
  input wire logic codeDetectEn,
  // pixels and line state
  output dsvf_pkg::dsvf_pix_t pixOut,
  output logic lineActive,
  output logic savPulse
);
  import dsvf_pkg::*;
  // whole state of the demultiplexer
  typedef struct packed {
    logic [7:0] hist0; logic [7:0] hist1; logic [7:0] hist2;
    logic [1:0] phase; logic [7:0] cb; logic [7:0] cr;
    logic active; logic sav; dsvf_pix_t pix;
  } dsvf_deser_state_t;
  dsvf_deser_state_t stateReg, stateNext;
  // next state
  always_comb
  begin
    stateNext = stateReg;
    stateNext.sav = 1'b0;
    stateNext.pix.valid = 1'b0;
    if (!codeDetectEn)
      stateNext.active = 1'b1; // free running without embedded codes
    if (wordStrobe)
    begin
      stateNext.hist0 = wordIn;
      stateNext.hist1 = stateReg.hist0;
      stateNext.hist2 = stateReg.hist1;
      if (codeDetectEn && stateReg.hist2 == CODE_FF && stateReg.hist1 == CODE_00
          && stateReg.hist0 == CODE_00)
      begin
        // timing word: realign, start or end the active line [R2]
        stateNext.phase = 2'h0;
        stateNext.active = !wordIn[CODE_H_BIT];
        stateNext.sav = !wordIn[CODE_H_BIT];
      end
      else
      begin
        // cb y cr y order [R2]
        stateNext.phase = stateReg.phase + 2'h1;
        case (stateReg.phase)
          2'h0: stateNext.cb = wordIn;
          2'h2: stateNext.cr = wordIn;
          default:
          begin
            stateNext.pix.valid = 1'b1;
            stateNext.pix.pix = '{y: wordIn, u: stateReg.cb, v: stateReg.cr};
          end
        endcase
      end
    end
  end
  // state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      stateReg <= '0;
    else
      stateReg <= stateNext;
  end
  assign pixOut = stateReg.pix;
  assign lineActive = stateReg.active;
  assign savPulse = stateReg.sav;
endmodule

// File: dsvf_keyed_blend.sv
// dual stream video fader: keyed three factor blender
// assumes inputs stand for the cycle in which inValid is high
module dsvf_keyed_blend #(parameter int unsigned FW = 6)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pixels
  input wire logic inValid,
  input dsvf_pkg::dsvf_yuv_t mpegIn,
  input dsvf_pkg::dsvf_yuv_t videoIn,
  input dsvf_pkg::dsvf_yuv_t lutColour,
  // keys, factors and modes
  input dsvf_pkg::dsvf_yuv_t key1Lo,
  input dsvf_pkg::dsvf_yuv_t key1Hi,
  input dsvf_pkg::dsvf_yuv_t key2Lo,
  input dsvf_pkg::dsvf_yuv_t key2Hi,
  input wire logic [FW-1:0] fade_factor_key_one,
  input wire logic [FW-1:0] fade_factor_table,
  input wire logic [FW-1:0] fade_factor_unkeyed,
  input wire logic tableFadeMpeg,
  input wire logic tableFadeVideo,
  input wire logic ignoreKeys,
  input wire logic passThrough,
  // result
  output dsvf_pkg::dsvf_pix_t blendOut,
  output logic key1Hit,
  output logic key2Hit
);
  import dsvf_pkg::*;
  localparam int unsigned FULL = 2 ** FW - 1;
  if (FW < 1 || FW > 8) $error("fade width must be 1 to 8");
  typedef struct packed {dsvf_pix_t out; logic hit1; logic hit2;} dsvf_blend_state_t;
  dsvf_blend_state_t stateReg, stateNext;
  // (FULL-n)/FULL of a plus n/FULL of b, rounded to nearest [R6] [R23]
  function automatic dsvf_yuv_t mix(input dsvf_yuv_t a, input dsvf_yuv_t b,
                                    input logic [FW-1:0] n);
    logic [17:0] acc;
    logic [23:0] res;
    res = '0;
    for (int i = 0; i < 3; i++)
    begin
      acc = (18'(FULL) - 18'(n)) * 18'(a[i*8 +: 8]) + 18'(n) * 18'(b[i*8 +: 8])
            + 18'(FULL / 2);
      res[i*8 +: 8] = 8'(acc / 18'(FULL));
    end
    mix = res;
  endfunction
  // colour lies inside the box lo..hi in all three components
  function automatic logic inBox(input dsvf_yuv_t c, input dsvf_yuv_t lo,
                                 input dsvf_yuv_t hi);
    inBox = c.y >= lo.y && c.y <= hi.y && c.u >= lo.u && c.u <= hi.u
            && c.v >= lo.v && c.v <= hi.v;
  endfunction
  // factor and operand choice per pixel
  always_comb
  begin
    stateNext = stateReg;
    stateNext.out.valid = inValid;
    stateNext.hit1 = inBox(mpegIn, key1Lo, key1Hi); // [R7]
    stateNext.hit2 = inBox(mpegIn, key2Lo, key2Hi); // [R9]
    if (inValid)
    begin
      if (passThrough)
        stateNext.out.pix = videoIn; // outside the active line, unfaded [R5]
      else if (tableFadeMpeg)
        stateNext.out.pix = mix(mpegIn, lutColour, fade_factor_table); // [R12]
      else if (tableFadeVideo)
        stateNext.out.pix = mix(lutColour, videoIn, fade_factor_table); // [R12]
      else if (ignoreKeys)
        stateNext.out.pix = mix(lutColour, videoIn, fade_factor_table); // [R11]
      else if (stateNext.hit1)
        stateNext.out.pix = mix(mpegIn, videoIn, fade_factor_key_one); // [R7] [R8]
      else if (stateNext.hit2)
        stateNext.out.pix = mix(lutColour, videoIn, fade_factor_table); // [R9]
      else
        stateNext.out.pix = mix(mpegIn, videoIn, fade_factor_unkeyed); // [R10]
    end
  end
  // state register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      stateReg <= '0;
    else
      stateReg <= stateNext;
  end
  assign blendOut = stateReg.out;
  assign key1Hit = stateReg.hit1;
  assign key2Hit = stateReg.hit2;
endmodule

// File: dsvf_top.sv
// dual stream video fader: encoder input stage, AHB-Lite registers
// assumes one 20 MHz clock; the line-locked clock and pixel port are async pins
// Notes on behaviour
// R1: capture one stream per line-locked clock edge
// R2: 8-bit cb-y-cr-y words, codes only slave mode
// R3: cross switch by two edge select bits
// R4: source keeps 00 and FF out of video
// R5: outside active line, video passes unfaded
// R6: output is factor mix of two inputs
// R7: key one box selects factor one
// R8: factor one 00 all mpeg, 3F all video
// R9: key two box blends table colour with video
// R10: otherwise factor three mixes mpeg and video
// R11: option ignores keys, fades against table
// R12: table fade bits per fader side
// R13: both routing bits: fader feeds both paths
// R14: rgb gets fader, composite gets stream b
// R15: rgb gets stream b, composite stream a
// R16: both zero: stream b feeds both paths
// R17: colour bars, eight steps per line
// R18: composite sync advance up to 31 clocks
// R19: reset gives pal, black composite, minimum rgb
// R20: reset abandons any bus transfer in progress
// R21: dematrix bypass puts cr y cb out
// R22: outputs oversampled twice per pixel
// R23: factor n weights video by n/63
//
// Added by the designer: register access over AHB-Lite and the address map.
module dsvf_top #(parameter int unsigned ACTIVE_PIXELS = dsvf_pkg::ACTIVE_PIXELS_DEF)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pixel port pins
  input wire logic lineLockedClock,
  input wire logic [7:0] pixelPort,
  // encoder feeds
  output dsvf_pkg::dsvf_yuv_t compositeOut,
  output dsvf_pkg::dsvf_rgb_t rgbOut,
  output logic sampleStrobe,
  output logic standardPal,
  output logic [4:0] syncAdvance
);
  import dsvf_pkg::*;
  localparam int unsigned CNT_W = $clog2(ACTIVE_PIXELS);
  localparam int unsigned BAR_LEN = ACTIVE_PIXELS / BAR_STEPS;
  if (ACTIVE_PIXELS % BAR_STEPS != 0 || ACTIVE_PIXELS < BAR_STEPS)
    $error("active pixel count must be a multiple of the bar count");

  // whole state of the top level
  typedef struct packed {
    logic [31:0] ctrl; // mode bits
    logic [31:0] fade; // three fade factors
    dsvf_yuv_t key1Lo; // key one lower corner
    dsvf_yuv_t key1Hi; // key one upper corner
    dsvf_yuv_t key2Lo; // key two lower corner
    dsvf_yuv_t key2Hi; // key two upper corner
    dsvf_yuv_t lut; // table colour
    logic llcMeta; // first synchroniser stage
    logic llcSync; // second synchroniser stage
    logic llcPrev; // for edge detection
    logic [7:0] pixMeta; // first synchroniser stage
    logic [7:0] pixSync; // second synchroniser stage
    logic [7:0] riseWord; // word of the rising edge
    logic [7:0] fallWord; // word of the falling edge
    logic riseStb; // new rising edge word
    logic fallStb; // new falling edge word
    dsvf_yuv_t heldA; // latest stream a pixel
    dsvf_yuv_t aDly; // stream a aligned with fader
    dsvf_yuv_t bDly; // stream b aligned with fader
    logic [CNT_W-1:0] pixCnt; // active pixel position
    dsvf_yuv_t prevComp; // last composite pixel
    dsvf_rgb_t prevRgb; // last rgb pixel
    logic halfPending; // second sample still owed
    dsvf_yuv_t compOut; // composite feed
    dsvf_rgb_t rgbOut; // rgb feed
    logic sampleStb; // feed update pulse
    logic [EARLY_W-1:0] syncAdv; // applied sync advance
    logic wrPend; // write data phase owed
    logic [7:0] wrAddr; // address of that write
    logic [31:0] rdData; // read data
    logic readyOut; // slave ready
  } dsvf_top_state_t;
  dsvf_top_state_t stateReg, stateNext;

  // stream side signals
  logic wordStbA, wordStbB;
  logic [7:0] wordA, wordB;
  logic codeDetect;
  dsvf_pix_t pixA, pixB, blendPix;
  logic activeA, activeB, savA, savB, key1Hit, key2Hit;
  dsvf_yuv_t barColour, mpegIn, videoIn;
  logic [2:0] barIdx;

  // rounded bytewise average, the half-way sample
  function automatic logic [23:0] avg3(input logic [23:0] a, input logic [23:0] b);
    logic [8:0] s;
    logic [23:0] r;
    r = '0;
    for (int i = 0; i < 3; i++)
    begin
      s = 9'(a[i*8 +: 8]) + 9'(b[i*8 +: 8]) + 9'h001;
      r[i*8 +: 8] = s[8:1];
    end
    avg3 = r;
  endfunction

  // limit a signed sum to the 8-bit code range
  function automatic logic [7:0] clamp8(input logic signed [19:0] x);
    if (x < 20'sh00000)
      clamp8 = RGB_MIN;
    else if (x > 20'sh000FF)
      clamp8 = 8'hFF;
    else
      clamp8 = x[7:0];
  endfunction

  // colour difference to rgb
  function automatic dsvf_rgb_t dematrix(input dsvf_yuv_t p);
    logic signed [19:0] yy, uu, vv;
    dsvf_rgb_t o;
    yy = signed'(20'(p.y));
    uu = signed'(20'(p.u)) - signed'(20'(CHROMA_MID));
    vv = signed'(20'(p.v)) - signed'(20'(CHROMA_MID));
    o.r = clamp8(yy + ((vv * DM_RV) >>> DM_SHIFT));
    o.g = clamp8(yy - ((uu * DM_GU + vv * DM_GV) >>> DM_SHIFT));
    o.b = clamp8(yy + ((uu * DM_BU) >>> DM_SHIFT));
    dematrix = o;
  endfunction

  // cross switch: each stream takes the edge its select bit names [R3]
  assign wordStbA = stateReg.ctrl[CB_EDGE_FIRST] ? stateReg.fallStb : stateReg.riseStb;
  assign wordA = stateReg.ctrl[CB_EDGE_FIRST] ? stateReg.fallWord : stateReg.riseWord;
  assign wordStbB = stateReg.ctrl[CB_EDGE_SECOND] ? stateReg.riseStb : stateReg.fallStb;
  assign wordB = stateReg.ctrl[CB_EDGE_SECOND] ? stateReg.riseWord : stateReg.fallWord;
  // code detection only in slave mode [R2]
  assign codeDetect = stateReg.ctrl[CB_CODE_DET] && stateReg.ctrl[CB_SLAVE];

  // stream a demultiplexer
  dsvf_stream_deser deserA
  (
    .clk(clk),
    .reset_n(reset_n),
    .wordStrobe(wordStbA),
    .wordIn(wordA),
    .codeDetectEn(codeDetect),
    .pixOut(pixA),
    .lineActive(activeA),
    .savPulse(savA)
  );

  // stream b demultiplexer
  dsvf_stream_deser deserB
  (
    .clk(clk),
    .reset_n(reset_n),
    .wordStrobe(wordStbB),
    .wordIn(wordB),
    .codeDetectEn(codeDetect),
    .pixOut(pixB),
    .lineActive(activeB),
    .savPulse(savB)
  );

  // colour bars, eight steps per line [R17]
  assign barIdx = 3'(stateReg.pixCnt / CNT_W'(BAR_LEN));
  assign barColour = BAR_TABLE[barIdx];
  // bars replace external data on both fader inputs
  assign mpegIn = stateReg.ctrl[CB_TEST_BARS] ? barColour : stateReg.heldA;
  assign videoIn = stateReg.ctrl[CB_TEST_BARS] ? barColour : pixB.pix;

  // keyed fader, paced by stream b
  dsvf_keyed_blend #(.FW(FADE_W)) fader
  (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(pixB.valid),
    .mpegIn(mpegIn),
    .videoIn(videoIn),
    .lutColour(stateReg.lut),
    .key1Lo(stateReg.key1Lo),
    .key1Hi(stateReg.key1Hi),
    .key2Lo(stateReg.key2Lo),
    .key2Hi(stateReg.key2Hi),
    .fade_factor_key_one(stateReg.fade[FADE_FACTOR_KEY_ONE_LSB +: FADE_W]),
    .fade_factor_table(stateReg.fade[FADE_FACTOR_TABLE_LSB +: FADE_W]),
    .fade_factor_unkeyed(stateReg.fade[FADE_FACTOR_UNKEYED_LSB +: FADE_W]),
    .tableFadeMpeg(stateReg.ctrl[CB_TFADE_MPEG]),
    .tableFadeVideo(stateReg.ctrl[CB_TFADE_VIDEO]),
    .ignoreKeys(stateReg.ctrl[CB_IGNORE_KEYS]),
    .passThrough(codeDetect && !activeB), // [R5]
    .blendOut(blendPix),
    .key1Hit(key1Hit),
    .key2Hit(key2Hit)
  );

  // next state of the whole top level
  always_comb
  begin
    logic addrPhase;
    logic [31:0] rd;
    dsvf_yuv_t compNew, rgbSrc;
    dsvf_rgb_t rgbNew;
    addrPhase = 1'b0;
    rd = '0;
    compNew = '0;
    rgbSrc = '0;
    rgbNew = '0;
    stateNext = stateReg;
    stateNext.riseStb = 1'b0;
    stateNext.fallStb = 1'b0;
    stateNext.sampleStb = 1'b0;
    stateNext.readyOut = 1'b1;

    // two stage synchronisers on the pins
    stateNext.llcMeta = lineLockedClock;
    stateNext.llcSync = stateReg.llcMeta;
    stateNext.llcPrev = stateReg.llcSync;
    stateNext.pixMeta = pixelPort;
    stateNext.pixSync = stateReg.pixMeta;

    // one word per edge of the line-locked clock [R1]
    if (stateReg.llcSync && !stateReg.llcPrev)
    begin
      stateNext.riseWord = stateReg.pixSync;
      stateNext.riseStb = 1'b1;
    end
    else if (!stateReg.llcSync && stateReg.llcPrev)
    begin
      stateNext.fallWord = stateReg.pixSync;
      stateNext.fallStb = 1'b1;
    end

    // hold stream a for pacing by stream b
    if (pixA.valid)
      stateNext.heldA = pixA.pix;
    if (pixB.valid)
    begin
      stateNext.aDly = mpegIn;
      stateNext.bDly = videoIn;
    end

    // active pixel counter for the bar generator [R17]
    if (savB)
      stateNext.pixCnt = '0;
    else if (pixB.valid && activeB)
      stateNext.pixCnt = (stateReg.pixCnt == CNT_W'(ACTIVE_PIXELS - 1)) ? '0
                         : stateReg.pixCnt + CNT_W'(1);

    // routing to the two encoders
    case ({stateReg.ctrl[CB_RGB_SEL], stateReg.ctrl[CB_COMP_SEL]})
      2'b11:
      begin
        compNew = blendPix.pix; // [R13]
        rgbSrc = blendPix.pix;
      end
      2'b10:
      begin
        compNew = stateReg.bDly; // [R14]
        rgbSrc = blendPix.pix;
      end
      2'b01:
      begin
        compNew = stateReg.aDly; // [R15]
        rgbSrc = stateReg.bDly;
      end
      default:
      begin
        compNew = stateReg.bDly; // [R16]
        rgbSrc = stateReg.bDly;
      end
    endcase

    // dematrix or its bypass [R21]
    if (stateReg.ctrl[CB_DEMATRIX_BYP])
      rgbNew = '{r: rgbSrc.v, g: rgbSrc.y, b: rgbSrc.u};
    else
      rgbNew = dematrix(rgbSrc);

    // two samples per pixel: midpoint, then pixel [R22]
    if (blendPix.valid)
    begin
      stateNext.compOut = avg3(stateReg.prevComp, compNew);
      stateNext.rgbOut = avg3(stateReg.prevRgb, rgbNew);
      stateNext.prevComp = compNew;
      stateNext.prevRgb = rgbNew;
      stateNext.halfPending = 1'b1;
      stateNext.sampleStb = 1'b1;
    end
    else if (stateReg.halfPending && wordStbB)
    begin
      stateNext.compOut = stateReg.prevComp; // [R22]
      stateNext.rgbOut = stateReg.prevRgb;
      stateNext.halfPending = 1'b0;
      stateNext.sampleStb = 1'b1;
    end

    // sync advance, zero when off [R18]
    stateNext.syncAdv = stateReg.ctrl[CB_EARLY_SYNC]
                        ? stateReg.ctrl[EARLY_LSB +: EARLY_W] : '0;

    // ahb data phase: pending write
    if (stateReg.wrPend)
    begin
      case (stateReg.wrAddr)
        OFS_CTRL: stateNext.ctrl = hwdata;
        OFS_FADE: stateNext.fade = hwdata;
        OFS_KEY1_LO: stateNext.key1Lo = hwdata[23:0];
        OFS_KEY1_HI: stateNext.key1Hi = hwdata[23:0];
        OFS_KEY2_LO: stateNext.key2Lo = hwdata[23:0];
        OFS_KEY2_HI: stateNext.key2Hi = hwdata[23:0];
        OFS_LUT: stateNext.lut = hwdata[23:0];
        default: stateNext.wrPend = 1'b0; // ignored
      endcase
    end

    // ahb address phase
    addrPhase = hsel && htrans[1] && hready;
    stateNext.wrPend = addrPhase && hwrite && haddr[31:8] == 24'h000000;
    stateNext.wrAddr = haddr[7:0];
    if (addrPhase && !hwrite)
    begin
      if (haddr[31:8] == 24'h000000)
      begin
        case (haddr[7:0])
          OFS_CTRL: rd = stateReg.ctrl;
          OFS_FADE: rd = stateReg.fade;
          OFS_KEY1_LO: rd = {8'h00, stateReg.key1Lo};
          OFS_KEY1_HI: rd = {8'h00, stateReg.key1Hi};
          OFS_KEY2_LO: rd = {8'h00, stateReg.key2Lo};
          OFS_KEY2_HI: rd = {8'h00, stateReg.key2Hi};
          OFS_LUT: rd = {8'h00, stateReg.lut};
          OFS_STATUS: rd = {16'(stateReg.pixCnt), 12'h000, key2Hit, key1Hit,
                            activeB, activeA};
          default: rd = '0;
        endcase
      end
      stateNext.rdData = rd;
    end
  end

  // state register; reset shows black
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stateReg <= '0; // pending bus write abandoned [R20]
      stateReg.ctrl <= CTRL_RESET; // pal standard [R19]
      stateReg.compOut <= '{y: BLACK_Y, u: CHROMA_MID, v: CHROMA_MID}; // [R19]
      stateReg.prevComp <= '{y: BLACK_Y, u: CHROMA_MID, v: CHROMA_MID};
      stateReg.rgbOut <= '{r: RGB_MIN, g: RGB_MIN, b: RGB_MIN}; // [R19]
      stateReg.prevRgb <= '{r: RGB_MIN, g: RGB_MIN, b: RGB_MIN};
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  // outputs straight from the state register, except hresp which is tied low
  assign hrdata = stateReg.rdData;
  assign hreadyout = stateReg.readyOut;
  assign hresp = 1'b0; // always okay
  assign compositeOut = stateReg.compOut;
  assign rgbOut = stateReg.rgbOut;
  assign sampleStrobe = stateReg.sampleStb;
  assign standardPal = stateReg.ctrl[CB_PAL];
  assign syncAdvance = stateReg.syncAdv;
endmodule

// File: dsvf_asserts.sv
// checker for the fader top, on its ports
// assumes it is bound into every dsvf_top instance
module dsvf_asserts
(
  // clock, reset and bus
  input logic clk, input logic reset_n, input logic hsel, input logic [31:0] haddr,
  input logic [1:0] htrans, input logic hwrite, input logic [31:0] hwdata,
  input logic hready, input logic hreadyout, input logic hresp,
  // encoder feeds
  input dsvf_pkg::dsvf_yuv_t compositeOut, input dsvf_pkg::dsvf_rgb_t rgbOut,
  input logic sampleStrobe, input logic standardPal, input logic [4:0] syncAdvance
);
  timeunit 1ns;
  timeprecision 1ns;
  import dsvf_pkg::*;
  logic ctrlWrPend; // control write in its data phase
  logic [31:0] ctrlShadow; // copy of the control word
  logic strobeOdd; // next strobe is the full sample
  logic [31:0] midCtrl; // control word behind the midpoint
  // shadow control writes, pair the feed samples
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      ctrlWrPend <= 1'b0;
      ctrlShadow <= CTRL_RESET;
      strobeOdd <= 1'b0;
      midCtrl <= '0;
    end
    else
    begin
      ctrlWrPend <= hsel && htrans[1] && hready && hwrite && haddr == {24'h0, OFS_CTRL};
      if (ctrlWrPend)
        ctrlShadow <= hwdata;
      if (sampleStrobe)
      begin
        strobeOdd <= !strobeOdd;
        midCtrl <= $past(ctrlShadow);
      end
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_reset_feeds: assert property (!$past(reset_n) |-> rgbOut == 24'h0 &&
    compositeOut == {BLACK_Y, CHROMA_MID, CHROMA_MID}) else $error("feeds not black");
  a_reset_pal: assert property (!$past(reset_n) |-> standardPal && syncAdvance == 5'h00)
    else $error("not pal after reset");
  a_bus_ready: assert property ($past(reset_n) |-> hreadyout && !hresp)
    else $error("bus not ready");
  a_pal_follows: assert property ($past(ctrlShadow, 2) == ctrlShadow |->
    standardPal == ctrlShadow[CB_PAL]) else $error("pal level wrong");
  a_sync_follows: assert property ($past(ctrlShadow, 2) == ctrlShadow |-> syncAdvance ==
    (ctrlShadow[CB_EARLY_SYNC] ? ctrlShadow[EARLY_LSB +: EARLY_W] : 5'h00))
    else $error("sync advance wrong");
  a_strobe_pulse: assert property (sampleStrobe |=> !sampleStrobe)
    else $error("strobe too long");
  a_feeds_hold: assert property (!sampleStrobe |-> $stable(compositeOut) && $stable(rgbOut))
    else $error("feed moved without strobe");
  a_paths_same: assert property (sampleStrobe && strobeOdd &&
    midCtrl[CB_DEMATRIX_BYP] && midCtrl[CB_RGB_SEL] == midCtrl[CB_COMP_SEL] |->
    rgbOut == {compositeOut.v, compositeOut.y, compositeOut.u}) else $error("paths differ");
endmodule
bind dsvf_top dsvf_asserts u_chk (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .compositeOut(compositeOut), .rgbOut(rgbOut), .sampleStrobe(sampleStrobe),
  .standardPal(standardPal), .syncAdvance(syncAdvance));

// File: dsvf_source_model.sv
// upstream source model: drives the double speed pixel port
// assumes the bench calls send; the clock pin stands still between calls
module dsvf_source_model
(
  input logic clk,
  output logic lineLockedClock,
  output logic [7:0] pixelPort
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    lineLockedClock = 1'b0;
    pixelPort = 8'hFF;
  end
  // one word per edge, held four clocks each side
  task automatic send(input logic [7:0] a, input logic [7:0] b);
    pixelPort <= a;
    repeat (4) @(posedge clk);
    lineLockedClock <= 1'b1;
    repeat (4) @(posedge clk);
    pixelPort <= b;
    repeat (4) @(posedge clk);
    lineLockedClock <= 1'b0;
    repeat (4) @(posedge clk);
    pixelPort <= ~b; // hold time over: show the inverse
    @(posedge clk);
  endtask
endmodule

// File: dsvf_tb_top.sv
// self-checking bench for the fader top
// assumes the source model paces the pixel port
module dsvf_tb_top import dsvf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam dsvf_yuv_t PA = 24'h6040C0, PB = 24'hA09070, LUT = 24'h3050B0;
  logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, lineLockedClock;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0] htrans = 2'h0;
  logic [7:0] pixelPort;
  logic hreadyout, hresp, sampleStrobe, standardPal;
  logic [4:0] syncAdvance;
  dsvf_yuv_t compositeOut;
  dsvf_rgb_t rgbOut;
  int badCount = 0, nCompared = 0;
  always #25 clk = ~clk;
  dsvf_top #(.ACTIVE_PIXELS(16)) u_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .lineLockedClock(lineLockedClock), .pixelPort(pixelPort), .compositeOut(compositeOut),
    .rgbOut(rgbOut), .sampleStrobe(sampleStrobe), .standardPal(standardPal),
    .syncAdvance(syncAdvance));
  dsvf_source_model u_src (.clk(clk), .lineLockedClock(lineLockedClock), .pixelPort(pixelPort));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp)
    begin
      badCount++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // one transfer: address then data phase
  task automatic busDo(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  function automatic dsvf_yuv_t mix(input dsvf_yuv_t p, input dsvf_yuv_t r, input int n);
    for (int i = 0; i < 3; i++)
      mix[i*8 +: 8] = 8'(((63 - n) * p[i*8 +: 8] + n * r[i*8 +: 8] + 31) / 63);
  endfunction
  // set mode, stream pixels, compare feeds
  task automatic row(input logic [31:0] ctrl, input logic [31:0] fade, input dsvf_yuv_t ec,
    input dsvf_yuv_t er);
    busDo(1'b1, OFS_CTRL, ctrl | 32'h400);
    busDo(1'b1, OFS_FADE, fade);
    repeat (3)
    begin
      u_src.send(8'h40, 8'h90);
      u_src.send(8'h60, 8'hA0);
      u_src.send(8'hC0, 8'h70);
      u_src.send(8'h60, 8'hA0);
    end
    repeat (8) @(posedge clk);
    check("composite", ec, compositeOut);
    check("rgb", {er.v, er.y, er.u}, rgbOut);
    $display("test done, ctrl %h", ctrl);
  endtask
  task automatic printVerdict();
    $display("compared %0d, wrong %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    busDo(1'b0, OFS_CTRL, 32'h0);
    check("ctrl", CTRL_RESET, q);
    busDo(1'b0, 8'h40, 32'h0);
    check("unmapped", 32'h0, q);
    busDo(1'b1, OFS_LUT, LUT);
    busDo(1'b0, OFS_LUT, 32'h0);
    check("lut", {8'h0, LUT}, q);
    busDo(1'b1, OFS_CTRL, 32'h001F_1800);
    repeat (3) @(posedge clk);
    check("advance", 32'h1F, {27'h0, syncAdvance});
    row(32'h0, 32'h0, PB, PB);
    row(32'h100, 32'h0, PA, PB);
    row(32'h80, 32'h200000, PB, mix(PA, PB, 32));
    row(32'h180, 32'h0, PA, PA);
    row(32'h180, 32'h3F0000, PB, PB);
    row(32'h1C0, 32'h0, LUT, LUT);
    row(32'h1A0, 32'h1000, mix(LUT, PB, 16), mix(LUT, PB, 16));
    row(32'h190, 32'h1000, mix(PA, LUT, 16), mix(PA, LUT, 16));
    busDo(1'b1, OFS_KEY1_HI, 32'hFFFFFF);
    row(32'h180, 32'h8, mix(PA, PB, 8), mix(PA, PB, 8));
    printVerdict();
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    badCount++;
    $display("watchdog expired");
    printVerdict();
  end
endmodule
